// file: pdc_chop_ff.sv
// set/reset chopper flip-flop of one output channel
module pdc_chop_ff (
    // clock and reset
    input wire logic sys_clk,
    input wire logic rst,
    // controls
    input wire logic enable,
    input wire logic set_pulse,
    input wire logic trip,
    input wire logic inhibit,
    // driver
    output logic drive
);

    // reset by trip dominates the chop set for current safety
    always_ff @(posedge sys_clk)
    begin
        if (rst || !enable)
            drive <= 1'b0;
        else if (inhibit)
            drive <= 1'b1;
        else if (trip)
            drive <= 1'b0;
        else if (set_pulse)
            drive <= 1'b1;
    end

endmodule // pdc_chop_ff

// file: pdc_driver_ctl.sv
// serial-in latched nine channel driver control with enable one-shot and chopper

// How it works
// - serial data enters the first stage on each serial clock rise.
// - each later rise moves stages toward serial data out, the last stage.
// - strobe falling edge copies all stages into the latches at once.
// - only channels latched high drive, and only during the enable interval.
// - strobe fall starts the one-shot in timed and host modes; it governs drivers and switch control.
// - timed mode interval is EN_COUNT system clock cycles, counted from the strobe fall.
// - host mode holds outputs on until a rise on the enable timing pin.
// - switch control is active during the interval, inactive outside it.
// - shifting between strobes leaves latches and driver outputs untouched.
// - each channel has its own flip-flop set by a fixed-rate chop pulse.
// - chop inhibit input keeps enabled outputs on without chopping.
// - sensed current trip resets the channel flip-flop until next chop pulse.
// - chop pulses go to odd and even channel groups at different times.
// - reset holds every output off during power-up.
module pdc_driver_ctl #(
    parameter logic [15:0] EN_COUNT = pdc_pkg::EN_CYCLES,
    parameter logic [15:0] CHOP_COUNT = pdc_pkg::CHOP_CYCLES
) (
    // clock and reset
    input wire logic sys_clk,
    input wire logic rst,
    // serial host link
    input wire logic serial_data_in,
    input wire logic serial_clk,
    input wire logic strobe,
    output logic serial_data_out,
    // enable timing pin and its configured mode
    input wire logic enable_timing_pin,
    input wire logic [1:0] enable_mode,
    // current control inputs
    input wire logic chop_inhibit,
    input wire logic [8:0] current_trip,
    // drivers
    output logic [8:0] driver_on,
    output logic external_switch_control
);

    // ------------------------------------------------------------
    // input synchronisation
    // ------------------------------------------------------------
    logic [6:0] pins_s;
    logic [8:0] trip_s;
    logic clk_prev;
    logic strobe_prev;
    logic pin_prev;

    pdc_sync #(.W(7)) u_sync_pins (
        .sys_clk(sys_clk),
        .rst(rst),
        .d({enable_mode, chop_inhibit, enable_timing_pin, strobe, serial_clk, serial_data_in}),
        .q(pins_s)
    );

    pdc_sync #(.W(9)) u_sync_trip (
        .sys_clk(sys_clk),
        .rst(rst),
        .d(current_trip),
        .q(trip_s)
    );

    // named views of synchronised pins
    wire data_s = pins_s[0];
    wire clk_s = pins_s[1];
    wire strobe_s = pins_s[2];
    wire pin_s = pins_s[3];
    wire inhibit_s = pins_s[4];
    wire [1:0] mode_s = pins_s[6:5];

    // edge detection on synchronised levels
    wire clk_rise = clk_s && !clk_prev;
    wire strobe_fall = !strobe_s && strobe_prev;
    wire pin_rise = pin_s && !pin_prev;
    wire mode_host = (mode_s == pdc_pkg::MODE_HOST);
    wire mode_cont = (mode_s == pdc_pkg::MODE_CONT);

    always_ff @(posedge sys_clk)
    begin
        if (rst)
        begin
            clk_prev <= 1'b0;
            strobe_prev <= 1'b0;
            pin_prev <= 1'b0;
        end
        else
        begin
            clk_prev <= clk_s;
            strobe_prev <= strobe_s;
            pin_prev <= pin_s;
        end
    end

    // ------------------------------------------------------------
    // shift register and latches
    // ------------------------------------------------------------
    logic [8:0] shift;
    logic [8:0] latch;

    // shift on clock rise, stage 0 takes the serial input
    always_ff @(posedge sys_clk)
    begin
        if (rst)
            shift <= pdc_pkg::RST_WORD;
        else if (clk_rise)
            shift <= {shift[7:0], data_s};
    end

    // last stage presented for cascading
    always_ff @(posedge sys_clk)
    begin
        if (rst)
            serial_data_out <= 1'b0;
        else
            serial_data_out <= shift[8];
    end

    // parallel copy only on strobe fall
    always_ff @(posedge sys_clk)
    begin
        if (rst)
            latch <= pdc_pkg::RST_WORD;
        else if (strobe_fall)
            latch <= shift;
    end

    // ------------------------------------------------------------
    // enable one-shot
    // ------------------------------------------------------------
    pdc_pkg::pdc_state_t state;
    pdc_pkg::pdc_state_t next_state;
    logic [15:0] en_cnt;
    logic [15:0] next_en_cnt;

    wire timed_done = (en_cnt == EN_COUNT - 16'h0001);
    wire en_active = (state != pdc_pkg::ST_IDLE) || mode_cont;

    // interval sequencing, a strobe fall restarts the interval
    always_comb
    begin
        next_state = state;
        next_en_cnt = en_cnt;
        if (strobe_fall)
        begin
            next_en_cnt = pdc_pkg::RST_CNT;
            if (mode_cont)
                next_state = pdc_pkg::ST_IDLE;
            else if (mode_host)
                next_state = pdc_pkg::ST_HOST;
            else
                next_state = pdc_pkg::ST_TIMED;
        end
        else
        begin
            case (state)
                pdc_pkg::ST_TIMED:
                begin
                    next_en_cnt = en_cnt + 16'h0001;
                    if (timed_done)
                        next_state = pdc_pkg::ST_IDLE;
                end
                pdc_pkg::ST_HOST:
                begin
                    if (pin_rise)
                        next_state = pdc_pkg::ST_IDLE;
                end
                pdc_pkg::ST_IDLE:
                    next_state = pdc_pkg::ST_IDLE;
                default:
                    next_state = pdc_pkg::ST_IDLE;
            endcase
        end
    end

    always_ff @(posedge sys_clk)
    begin
        if (rst)
        begin
            state <= pdc_pkg::ST_IDLE;
            en_cnt <= pdc_pkg::RST_CNT;
        end
        else
        begin
            state <= next_state;
            en_cnt <= next_en_cnt;
        end
    end

    // switch control follows the interval
    always_ff @(posedge sys_clk)
    begin
        if (rst)
            external_switch_control <= 1'b0;
        else
            external_switch_control <= en_active;
    end

    // ------------------------------------------------------------
    // chop oscillator and channels
    // ------------------------------------------------------------
    logic [15:0] chop_cnt;

    wire chop_wrap = (chop_cnt == CHOP_COUNT - 16'h0001);
    wire odd_pulse = (chop_cnt == 16'h0000);
    wire even_pulse = (chop_cnt == (CHOP_COUNT >> 1));

    // free-running chop period counter
    always_ff @(posedge sys_clk)
    begin
        if (rst || chop_wrap)
            chop_cnt <= pdc_pkg::RST_CNT;
        else
            chop_cnt <= chop_cnt + 16'h0001;
    end

    // bit 0 is channel 1, so even bit indices form the odd group
    for (genvar i = 0; i < pdc_pkg::CHANNELS; i++)
    begin : g_chan
        pdc_chop_ff u_ff (
            .sys_clk(sys_clk),
            .rst(rst),
            .enable(en_active && latch[i]),
            .set_pulse((i % 2 == 0) ? odd_pulse : even_pulse),
            .trip(trip_s[i]),
            .inhibit(inhibit_s),
            .drive(driver_on[i])
        );
    end

    // ------------------------------------------------------------
    // assertions
    // ------------------------------------------------------------
    default clocking cb @(posedge sys_clk);
    endclocking
    default disable iff (rst);

    a_shift_sample: assert property (clk_rise |=> shift[0] == $past(data_s))
        else $error("first stage missed serial data");
    a_shift_move: assert property (clk_rise |=> shift[8:1] == $past(shift[7:0]))
        else $error("stages did not shift");
    a_out_last: assert property (##1 serial_data_out == $past(shift[8]))
        else $error("serial out not last stage");
    a_latch_copy: assert property (strobe_fall |=> latch == $past(shift))
        else $error("latch did not copy shift register");
    a_latch_hold: assert property (!strobe_fall |=> $stable(latch))
        else $error("latch changed without strobe");
    a_drive_gated: assert property (##1 (driver_on & ~$past(latch)) == 9'h000
        && (driver_on == 9'h000 || $past(en_active)))
        else $error("channel drove outside latch or interval");
    a_strobe_start: assert property (strobe_fall |=> en_active ##1 external_switch_control)
        else $error("strobe did not start interval");
    a_timed_hold: assert property (strobe_fall && !mode_cont && !mode_host
        |=> (state == pdc_pkg::ST_TIMED)[*8])
        else $error("timed interval ended early");
    a_timed_end: assert property (state == pdc_pkg::ST_TIMED && timed_done && !strobe_fall
        |=> state == pdc_pkg::ST_IDLE)
        else $error("timed interval overran");
    a_host_end: assert property (state == pdc_pkg::ST_HOST && pin_rise && !strobe_fall
        |=> state == pdc_pkg::ST_IDLE)
        else $error("host disable ignored");
    a_switch_follow: assert property (##1 external_switch_control == $past(en_active))
        else $error("switch control not following interval");
    a_inhibit_on: assert property (inhibit_s && en_active |=> driver_on == $past(latch))
        else $error("inhibit did not hold outputs on");
    a_chop_set: assert property (odd_pulse && en_active && !inhibit_s
        |=> driver_on[0] == $past(latch[0] && !trip_s[0]))
        else $error("chop pulse did not set channel");
    a_trip_off: assert property (!inhibit_s |=> (driver_on & $past(trip_s)) == 9'h000)
        else $error("tripped channel still on");
    a_group_split: assert property (!(odd_pulse && even_pulse))
        else $error("both chop groups pulsed together");
    a_reset_off: assert property (disable iff (1'b0) rst |=> driver_on == 9'h000
        && !external_switch_control)
        else $error("output active after reset");

    // interval hold, continuous mode and even group checks
    a_host_hold: assert property (state == pdc_pkg::ST_HOST && !pin_rise && !strobe_fall
        |=> state == pdc_pkg::ST_HOST)
        else $error("host interval ended without disable");
    a_cont_on: assert property (mode_cont |=> external_switch_control)
        else $error("continuous mode switch control off");
    a_cont_strobe: assert property (strobe_fall && mode_cont |=> state == pdc_pkg::ST_IDLE)
        else $error("continuous mode started a one-shot");
    a_idle_off: assert property (state == pdc_pkg::ST_IDLE && !mode_cont |=> !external_switch_control)
        else $error("switch control on outside interval");
    a_even_set: assert property (even_pulse && en_active && !inhibit_s
        |=> driver_on[1] == $past(latch[1] && !trip_s[1]))
        else $error("chop pulse did not set even channel");

    // main scenarios reached
    c_timed_cycle: cover property (strobe_fall && !mode_host && !mode_cont ##[1:1000] !en_active);
    c_host_cycle: cover property (state == pdc_pkg::ST_HOST ##[1:1000] pin_rise);
    c_chop_trip: cover property (driver_on[0] ##1 !driver_on[0] && en_active ##[1:200] driver_on[0]);
    c_inhibit: cover property (inhibit_s && driver_on != 9'h000);
    c_cont_mode: cover property (mode_cont && driver_on != 9'h000);

endmodule // pdc_driver_ctl

// file: pdc_driver_ctl_bench.sv
// self-checking bench of the serial latched print driver control
module pdc_driver_ctl_bench;
    timeunit 1ns;
    timeprecision 1ns;

    // ------------------------------------------------------------
    // settings, rows and signals
    // ------------------------------------------------------------
    localparam logic [15:0] EN_N = 16'h0028;
    localparam logic [15:0] CHOP_N = 16'h000A;
    localparam int LIMIT = 5000;

    typedef struct packed
    {
        logic [8:0] word;
        logic [8:0] drive;
        logic sdo;
    } pdc_row_t;

    pdc_row_t rows [5] = '{'{9'h1FF, 9'h1FF, 1'h1}, '{9'h155, 9'h155, 1'h1},
        '{9'h0AA, 9'h0AA, 1'h0}, '{9'h001, 9'h001, 1'h0}, '{9'h100, 9'h100, 1'h1}};
    logic sys_clk;
    logic rst;
    logic serial_data_in;
    logic serial_clk;
    logic strobe;
    logic serial_data_out;
    logic enable_timing_pin;
    logic [1:0] enable_mode;
    logic chop_inhibit;
    logic [8:0] current_trip;
    logic [8:0] driver_on;
    logic external_switch_control;
    // gate drive of a p-channel high-side switch, low turns it on
    wire p_switch_on_n = !external_switch_control;
    logic saw_split;
    int err_count;
    int comparisons;
    int cycles;

    pdc_driver_ctl #(
        .EN_COUNT(EN_N),
        .CHOP_COUNT(CHOP_N)
    ) dut (
        .sys_clk(sys_clk),
        .rst(rst),
        .serial_data_in(serial_data_in),
        .serial_clk(serial_clk),
        .strobe(strobe),
        .serial_data_out(serial_data_out),
        .enable_timing_pin(enable_timing_pin),
        .enable_mode(enable_mode),
        .chop_inhibit(chop_inhibit),
        .current_trip(current_trip),
        .driver_on(driver_on),
        .external_switch_control(external_switch_control)
    );

    pdc_host_model host (
        .sys_clk(sys_clk),
        .serial_data_in(serial_data_in),
        .serial_clk(serial_clk),
        .strobe(strobe)
    );

    // ------------------------------------------------------------
    // helpers
    // ------------------------------------------------------------
    task automatic check(input logic [8:0] seen, input logic [8:0] exp);
        comparisons++;
        if (seen !== exp)
        begin
            err_count++;
            $display("[FAIL] %0t ns seen %h expected %h", $time, seen, exp);
        end
    endtask

    task automatic wrap_up();
        if (err_count == 0 && comparisons > 0)
            $display("== PASSED ==");
        else
            $display("== FAILED ==");
        $finish;
    endtask

    // clock
    initial
    begin
        sys_clk = 1'h0;
        forever #50 sys_clk = ~sys_clk;
    end

    // hang guard
    always @(posedge sys_clk)
    begin
        cycles++;
        if (cycles == LIMIT)
        begin
            err_count++;
            wrap_up();
        end
    end

    // ------------------------------------------------------------
    // main sequence
    // ------------------------------------------------------------
    initial
    begin
        err_count = 0;
        comparisons = 0;
        cycles = 0;
        saw_split = 1'h0;
        rst = 1'h1;
        enable_timing_pin = 1'h0;
        enable_mode = pdc_pkg::MODE_TIMED;
        chop_inhibit = 1'h1;
        current_trip = 9'h000;
        repeat (10) @(posedge sys_clk);
        check(driver_on, 9'h000);
        check({7'h00, external_switch_control, serial_data_out}, 9'h000);
        repeat (10) @(posedge sys_clk);
        rst <= 1'h0;
        repeat (3) @(posedge sys_clk);
        // timed intervals, no chopping
        foreach (rows[i])
        begin
            host.send(rows[i].word, 1'h1);
            repeat (4) @(posedge sys_clk);
            check(driver_on, rows[i].drive);
            check({8'h00, external_switch_control}, 9'h001);
            check({8'h00, p_switch_on_n}, 9'h000);
            check({8'h00, serial_data_out}, {8'h00, rows[i].sdo});
            repeat (EN_N) @(posedge sys_clk);
            check(driver_on, 9'h000);
            check({8'h00, external_switch_control}, 9'h000);
            check({8'h00, p_switch_on_n}, 9'h001);
        end
        // host mode with chopping, trip and a new word mid-interval
        enable_mode <= pdc_pkg::MODE_HOST;
        chop_inhibit <= 1'h0;
        host.send(9'h1FF, 1'h0);
        host.send(9'h1FF, 1'h1);
        // watch for channel 1 and 2 coming on at different chop pulses
        repeat (20)
        begin
            @(posedge sys_clk);
            if (driver_on[0] !== driver_on[1])
                saw_split = 1'h1;
        end
        check({8'h00, saw_split}, 9'h001);
        check(driver_on, 9'h1FF);
        current_trip <= 9'h001;
        repeat (6) @(posedge sys_clk);
        check(driver_on, 9'h1FE);
        current_trip <= 9'h000;
        repeat (CHOP_N + 6) @(posedge sys_clk);
        check(driver_on, 9'h1FF);
        host.send(9'h000, 1'h0);
        check(driver_on, 9'h1FF);
        check({8'h00, serial_data_out}, 9'h000);
        chop_inhibit <= 1'h1;
        current_trip <= 9'h1FF;
        repeat (6) @(posedge sys_clk);
        check(driver_on, 9'h1FF);
        current_trip <= 9'h000;
        enable_timing_pin <= 1'h1;
        repeat (8) @(posedge sys_clk);
        check(driver_on, 9'h000);
        check({8'h00, external_switch_control}, 9'h000);
        // continuous mode with grounded timing pin, then reset mid-run
        enable_timing_pin <= 1'h0;
        enable_mode <= pdc_pkg::MODE_CONT;
        host.send(9'h0F0, 1'h1);
        repeat (EN_N + 20) @(posedge sys_clk);
        check(driver_on, 9'h0F0);
        rst <= 1'h1;
        repeat (3) @(posedge sys_clk);
        check(driver_on, 9'h000);
        rst <= 1'h0;
        repeat (6) @(posedge sys_clk);
        check(driver_on, 9'h000);
        check({8'h00, external_switch_control}, 9'h001);
        wrap_up();
    end
endmodule // pdc_driver_ctl_bench

// file: pdc_host_model.sv
// host controller model that drives the serial link of the driver control
module pdc_host_model (
    // clock
    input wire logic sys_clk,
    // serial link pins
    output logic serial_data_in,
    output logic serial_clk,
    output logic strobe
);
    timeunit 1ns;
    timeprecision 1ns;

    // idle levels: pulled-up data, clock still, strobe high
    initial
    begin
        serial_data_in = 1'h1;
        serial_clk = 1'h0;
        strobe = 1'h1;
    end

    // shifts a word msb first at an 800 ns clock, then strobes if asked
    task automatic send(input logic [8:0] word, input logic latch_it);
        for (int i = 8; i >= 0; i--)
        begin
            serial_data_in <= word[i];
            repeat (4) @(posedge sys_clk);
            serial_clk <= 1'h1;
            repeat (4) @(posedge sys_clk);
            serial_clk <= 1'h0;
        end
        serial_data_in <= 1'h1;
        repeat (8) @(posedge sys_clk);
        if (latch_it)
        begin
            strobe <= 1'h0;
            repeat (8) @(posedge sys_clk);
            strobe <= 1'h1;
        end
    endtask
endmodule // pdc_host_model

// file: pdc_pkg.sv
// shared constants of the serial latched print driver control
package pdc_pkg;

    // ------------------------------------------------------------
    // sizes
    // ------------------------------------------------------------
    localparam int CHANNELS = 9;
    localparam int CNT_W = 16;

    // ------------------------------------------------------------
    // timing
    // ------------------------------------------------------------
    localparam int CLK_PERIOD_NS = 100;
    localparam int EN_TIME_NS = 200000;
    localparam int CHOP_PERIOD_NS = 10000;
    localparam int STROBE_GAP_NS = 500;
    // timeout and chop period are exact, so plain division
    localparam logic [15:0] EN_CYCLES = 16'(EN_TIME_NS / CLK_PERIOD_NS);
    localparam logic [15:0] CHOP_CYCLES = 16'(CHOP_PERIOD_NS / CLK_PERIOD_NS);

    // ------------------------------------------------------------
    // enable interval modes and controller states
    // ------------------------------------------------------------
    localparam logic [1:0] MODE_TIMED = 2'h0;
    localparam logic [1:0] MODE_HOST = 2'h1;
    localparam logic [1:0] MODE_CONT = 2'h2;

    typedef enum logic [2:0]
    {
        ST_IDLE = 3'b001,
        ST_TIMED = 3'b010,
        ST_HOST = 3'b100
    } pdc_state_t;

    // ------------------------------------------------------------
    // reset values
    // ------------------------------------------------------------
    localparam logic [8:0] RST_WORD = 9'h000;
    localparam logic [15:0] RST_CNT = 16'h0000;

endpackage

// file: pdc_sync.sv
// two flip-flop synchroniser for pin inputs
module pdc_sync #(
    parameter int W = 1
) (
    // clock and reset
    input wire logic sys_clk,
    input wire logic rst,
    // pins in, synchronised levels out
    input wire logic [W-1:0] d,
    output logic [W-1:0] q
);

    logic [W-1:0] meta;

    // first stage is read only by the second
    always_ff @(posedge sys_clk)
    begin
        if (rst)
        begin
            meta <= '0;
            q <= '0;
        end
        else
        begin
            meta <= d;
            q <= meta;
        end
    end

endmodule // pdc_sync
